// [rtl/dar_top.sv]
// query responder for demodulator alarms and link quality, AXI4-Lite slave
`timescale 1ns/1ns

// How it works
// RULE1: latched query returns six bytes in order
// RULE2: current query returns same layout, live faults
// RULE3: defined bits fail as one, spares zero
// RULE4: alarm byte one holds receive faults
// RULE5: alarm byte two holds buffer, LNB faults
// RULE6: alarm byte three holds lock faults
// RULE7: alarm byte four holds clock activity
// RULE8: common byte holds supplies and housekeeping
// RULE9: alarm byte five holds framing alarms
// RULE10: frame sync bit one, prompt bit four
// RULE11: second bit-five entries move to six
// RULE12: latched bit sets on fail, host clears
// RULE13: quality query returns twelve bytes in order
// RULE14: BER mantissa two bytes, exponent separate
// RULE15: Eb/No sent as dB times hundred
// RULE16: status bits zero, one give BER validity
// RULE17: status bits two, three qualify Eb/No
// RULE18: input level magnitude in dB steps
// RULE19: level state signed, zero one minus one
// RULE20: AGC voltage passed as hex-coded byte
module dar_top
    import dar_pkg::*;
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // fault pins, asynchronous, one means fail
    input  wire logic [`DAR_RX_W-1:0] rx_flt,
    input  wire logic [`DAR_BUF_W-1:0] buf_flt,
    input  wire logic [`DAR_PLL_W-1:0] pll_flt,
    input  wire logic [`DAR_CLK_W-1:0] clk_flt,
    input  wire logic [`DAR_SUP_W-1:0] sup_flt,
    input  wire logic [`DAR_FRM_W-1:0] frm_flt,
    // link quality figures from the measurement logic, same clock
    input  wire logic [15:0]          raw_ber_man,
    input  wire logic [15:0]          cor_ber_man,
    input  wire logic [7:0]           raw_ber_exp,
    input  wire logic [7:0]           cor_ber_exp,
    input  wire logic [15:0]          ebno_cdb,
    input  wire logic                 ber_valid,
    input  wire logic                 tp_ber_valid,
    input  wire logic [1:0]           ebno_qual,
    input  wire logic [7:0]           in_level,
    input  wire logic [7:0]           level_state,
    input  wire logic [7:0]           agc_volt
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam dar_state_s RST = '{st: ST_IDLE, kind: KIND_LAT, default: '0};

    dar_state_s                     q;        // registered state
    dar_state_s                     d;        // next state
    logic [`DAR_FLT_W-1:0]          flt;      // filtered fault vector
    logic [5:0][7:0]                cur;      // current alarm bytes
    logic [`DAR_RESP_BYTES-1:0][7:0] qual;    // quality payload
    logic                           wr_fire;  // stored write is executed
    logic                           cmd_we;   // write to command register
    logic                           clr_we;   // write to clear register
    logic                           cmd_go;   // accepted query
    logic                           op_ok;    // opcode is a known query

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // word address match, low two bits ignored
    function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
        is_off = (a[7:2] == off[7:2]);
    endfunction

    // one payload byte for the response kind and index
    function automatic logic [7:0] pick(input dar_kind_e k, input logic [3:0] i,
                                        input logic [5:0][7:0] c,
                                        input logic [5:0][7:0] l,
                                        input logic [`DAR_RESP_BYTES-1:0][7:0] qb);
        unique case (k)
            KIND_QUAL: pick = qb[i];
            KIND_CUR:  pick = c[i[2:0]];
            default:   pick = l[i[2:0]];
        endcase
    endfunction

    // ----------------------------------------------------------------
    // fault pin synchroniser
    // ----------------------------------------------------------------
    dar_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  ({frm_flt, sup_flt, clk_flt, pll_flt, buf_flt, rx_flt}),
        .flt_out (flt)
    );

    // ----------------------------------------------------------------
    // current alarm bytes
    // ----------------------------------------------------------------
    // RULE3: spare bits tied to pass
    // RULE4: receive faults, forced alarm from config
    // RULE11: uncorrectable word sits at bit six
    assign cur[`DAR_AB1] = {q.cfg[`DAR_CFG_FORCE], flt[`DAR_RX_LO +: `DAR_RX_W]};
    // RULE5: buffer faults, LNB only when variant enabled
    assign cur[`DAR_AB2] = {2'h0,
                            flt[`DAR_BUF_LO + `DAR_LNB_BIT] & q.cfg[`DAR_CFG_LNB],
                            flt[`DAR_BUF_LO +: `DAR_LNB_BIT]};
    // RULE6: lock faults, external reference lock at bit six
    assign cur[`DAR_AB3] = flt[`DAR_PLL_LO +: `DAR_PLL_W];
    // RULE7: clock activity faults, upper nibble spare
    assign cur[`DAR_AB4] = {4'h0, flt[`DAR_CLK_LO +: `DAR_CLK_W]};
    // RULE8: supply and housekeeping, bit seven spare
    assign cur[`DAR_ABC] = {1'b0, flt[`DAR_SUP_LO +: `DAR_SUP_W]};
    // RULE9: framing alarms, bit two and top spare
    // RULE10: frame sync at bit one, prompt at bit four
    assign cur[`DAR_AB5] = {2'h0, flt[`DAR_FRM_LO + 4], flt[`DAR_FRM_LO + 3],
                            flt[`DAR_FRM_LO + 2], 1'b0, flt[`DAR_FRM_LO +: 2]};

    // ----------------------------------------------------------------
    // link quality payload, high byte first in two-byte fields
    // ----------------------------------------------------------------
    // RULE13: field order of the quality answer
    // RULE14: mantissas here, exponents at six and seven
    assign qual[0]  = raw_ber_man[`DAR_HI_BYTE];
    assign qual[1]  = raw_ber_man[`DAR_LO_BYTE];
    assign qual[2]  = cor_ber_man[`DAR_HI_BYTE];
    assign qual[3]  = cor_ber_man[`DAR_LO_BYTE];
    // RULE15: Eb/No in hundredths of a dB
    assign qual[4]  = ebno_cdb[`DAR_HI_BYTE];
    assign qual[5]  = ebno_cdb[`DAR_LO_BYTE];
    assign qual[6]  = raw_ber_exp;
    assign qual[7]  = cor_ber_exp;
    // RULE16: validity bits, upper nibble reserved zero
    // RULE17: Eb/No qualifier in bits two and three
    assign qual[`DAR_QB_STATUS] = {4'h0, ebno_qual, tp_ber_valid, ber_valid};
    // RULE18: level magnitude, sign implied
    assign qual[9]  = in_level;
    // RULE19: signed level state passed unchanged
    assign qual[10] = level_state;
    // RULE20: hex-coded AGC voltage passed unchanged
    assign qual[11] = agc_volt;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
    assign cmd_we  = wr_fire && is_off(q.awaddr, `DAR_OFF_CMD) && (&q.wstrb[1:0]);
    assign clr_we  = wr_fire && is_off(q.awaddr, `DAR_OFF_CLR) && q.wstrb[0];
    assign op_ok   = (q.wdata[15:0] == `DAR_OP_LATCHED) ||
                     (q.wdata[15:0] == `DAR_OP_CURRENT) ||
                     (q.wdata[15:0] == `DAR_OP_QUALITY);
    assign cmd_go  = cmd_we && op_ok && (q.st == ST_IDLE);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [5:0][7:0] clr;   // per-byte clear mask
        clr = '0;
        d   = q;

        // capture address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end

        // execute the write once both halves are in
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `DAR_AXI_OKAY;
            if (is_off(q.awaddr, `DAR_OFF_CFG)) begin
                // config byte lane zero only
                if (q.wstrb[0]) begin
                    d.cfg = q.wdata[`DAR_CFG_W-1:0];
                end
            end else if (!(is_off(q.awaddr, `DAR_OFF_CMD) || is_off(q.awaddr, `DAR_OFF_CLR) ||
                           is_off(q.awaddr, `DAR_OFF_STAT) ||
                           is_off(q.awaddr, `DAR_OFF_RESP0) ||
                           is_off(q.awaddr, `DAR_OFF_RESP1) ||
                           is_off(q.awaddr, `DAR_OFF_RESP2))) begin
                // nothing lives here
                d.bresp = `DAR_AXI_DECERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // RULE12: clear selected latched bytes by host write
        if (clr_we) begin
            for (int i = 0; i < 6; i++) begin
                clr[i] = {8{q.wdata[i]}};
            end
        end
        // RULE12: a failing bit sets and wins over clear
        d.lat = (q.lat & ~clr) | cur;

        // fill sequencer
        unique case (q.st)
            ST_IDLE: begin
                if (cmd_we && (q.st == ST_IDLE)) begin
                    d.opcode     = q.wdata[15:0];
                    d.bad_op     = !op_ok;
                    d.resp_valid = 1'b0;
                end
                if (cmd_go) begin
                    // RULE1: latched answer, six bytes
                    // RULE2: current answer, same six bytes
                    // RULE13: quality answer, twelve bytes
                    d.st   = ST_FILL;
                    d.ptr  = 4'h0;
                    d.resp = '0;
                    if (q.wdata[15:0] == `DAR_OP_QUALITY) begin
                        d.kind = KIND_QUAL;
                        d.len  = `DAR_LEN_QUAL;
                    end else if (q.wdata[15:0] == `DAR_OP_CURRENT) begin
                        d.kind = KIND_CUR;
                        d.len  = `DAR_LEN_ALARM;
                    end else begin
                        d.kind = KIND_LAT;
                        d.len  = `DAR_LEN_ALARM;
                    end
                end
            end
            ST_FILL: begin
                // RULE1: one byte per cycle in answer order
                d.resp[q.ptr] = pick(q.kind, q.ptr, cur, q.lat, qual);
                d.ptr         = q.ptr + 4'h1;
                if (q.ptr == q.len - 4'h1) begin
                    d.st         = ST_IDLE;
                    d.resp_valid = 1'b1;
                end
            end
            default: begin
                // illegal code, fall back to idle
                d.st = ST_IDLE;
            end
        endcase

        // register reads
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `DAR_AXI_OKAY;
            d.rdata  = '0;
            if (is_off(s_axi_araddr, `DAR_OFF_CMD)) begin
                d.rdata[15:0] = q.opcode;
            end else if (is_off(s_axi_araddr, `DAR_OFF_STAT)) begin
                d.rdata[`DAR_ST_VALID] = q.resp_valid;
                d.rdata[`DAR_ST_BADOP] = q.bad_op;
                d.rdata[`DAR_ST_BUSY]  = (q.st == ST_FILL);
                d.rdata[`DAR_ST_LEN]   = q.len;
                d.rdata[`DAR_ST_OP]    = q.opcode;
            end else if (is_off(s_axi_araddr, `DAR_OFF_CFG)) begin
                d.rdata[`DAR_CFG_W-1:0] = q.cfg;
            end else if (is_off(s_axi_araddr, `DAR_OFF_RESP0)) begin
                d.rdata = {q.resp[3], q.resp[2], q.resp[1], q.resp[0]};
            end else if (is_off(s_axi_araddr, `DAR_OFF_RESP1)) begin
                d.rdata = {q.resp[7], q.resp[6], q.resp[5], q.resp[4]};
            end else if (is_off(s_axi_araddr, `DAR_OFF_RESP2)) begin
                d.rdata = {q.resp[11], q.resp[10], q.resp[9], q.resp[8]};
            end else if (!is_off(s_axi_araddr, `DAR_OFF_CLR)) begin
                // unmapped read answers zero with decode error
                d.rresp = `DAR_AXI_DECERR;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // bus outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready  = !q.w_got && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // RULE12: live failure shows in latch next cycle
    latch_set_a: assert property ( // RULE12
        (cur != '0) |=> ((q.lat & $past(cur)) == $past(cur)))
        else $error("latched byte missed a live fault");

    // RULE12: latched bits hold without a clear
    latch_keep_a: assert property ( // RULE12
        !clr_we |=> ((q.lat & $past(q.lat)) == $past(q.lat)))
        else $error("latched bit dropped without clear");

    // RULE3: spare positions read as pass
    spare_zero_a: assert property ( // RULE3
        (cur[`DAR_AB2][7:6] == 2'h0) && (cur[`DAR_AB4][7:4] == 4'h0) &&
        (cur[`DAR_ABC][7] == 1'b0) && (cur[`DAR_AB5][7:6] == 2'h0) &&
        (cur[`DAR_AB5][2] == 1'b0))
        else $error("spare alarm bit set");

    // RULE5: LNB bit gated by variant enable
    lnb_gate_a: assert property ( // RULE5
        !q.cfg[`DAR_CFG_LNB] |-> (cur[`DAR_AB2][`DAR_LNB_BIT] == 1'b0))
        else $error("LNB fault shown on plain variant");

    // RULE4: forced alarm reaches latched byte
    force_lat_a: assert property ( // RULE4
        q.cfg[`DAR_CFG_FORCE] |=> q.lat[`DAR_AB1][7])
        else $error("forced alarm not latched");

    // RULE13: quality answer ready thirteen cycles on
    qual_len_a: assert property ( // RULE13
        (cmd_go && (q.wdata[15:0] == `DAR_OP_QUALITY)) |=>
        (!q.resp_valid)[*8] ##4 !q.resp_valid ##1 q.resp_valid)
        else $error("quality answer length wrong");

    // RULE1: alarm answer ready seven cycles on
    alarm_len_a: assert property ( // RULE1
        (cmd_go && (q.wdata[15:0] != `DAR_OP_QUALITY)) |-> ##7 q.resp_valid)
        else $error("alarm answer length wrong");

    // RULE2: current answer carries live byte
    cur_byte_a: assert property ( // RULE2
        (q.st == ST_FILL && q.kind == KIND_CUR && q.ptr == 4'h4) |=>
        (q.resp[4] == $past(cur[`DAR_ABC])))
        else $error("current common byte wrong");

    // RULE16: status byte written with validity bits
    stat_byte_a: assert property ( // RULE16
        (q.st == ST_FILL && q.kind == KIND_QUAL && q.ptr == 4'h8) |=>
        (q.resp[`DAR_QB_STATUS] == {4'h0, $past(ebno_qual), $past(tp_ber_valid),
                                    $past(ber_valid)}))
        else $error("status byte wrong");

endmodule

// [inc/dar_consts.svh]
// named constants for the demodulator alarm and status responder
`ifndef DAR_CONSTS_SVH
`define DAR_CONSTS_SVH

// ----------------------------------------------------------------
// query opcodes and response lengths
// ----------------------------------------------------------------
`define DAR_OP_LATCHED  16'h2406
`define DAR_OP_CURRENT  16'h2409
`define DAR_OP_QUALITY  16'h240d
`define DAR_LEN_ALARM   4'h6
`define DAR_LEN_QUAL    4'hc
`define DAR_RESP_BYTES  12

// ----------------------------------------------------------------
// register byte offsets and bus answers
// ----------------------------------------------------------------
`define DAR_OFF_CMD     8'h00
`define DAR_OFF_CLR     8'h04
`define DAR_OFF_STAT    8'h08
`define DAR_OFF_CFG     8'h0c
`define DAR_OFF_RESP0   8'h10
`define DAR_OFF_RESP1   8'h14
`define DAR_OFF_RESP2   8'h18
`define DAR_AXI_OKAY    2'b00
`define DAR_AXI_DECERR  2'b11

// ----------------------------------------------------------------
// register fields
// ----------------------------------------------------------------
`define DAR_CFG_LNB     0
`define DAR_CFG_FORCE   1
`define DAR_CFG_W       2
`define DAR_ST_VALID    0
`define DAR_ST_BADOP    1
`define DAR_ST_BUSY     2
`define DAR_ST_LEN      11:8
`define DAR_ST_OP       31:16
`define DAR_HI_BYTE     15:8
`define DAR_LO_BYTE     7:0

// ----------------------------------------------------------------
// fault input vector layout
// ----------------------------------------------------------------
`define DAR_RX_LO       0
`define DAR_RX_W        7
`define DAR_BUF_LO      7
`define DAR_BUF_W       6
`define DAR_PLL_LO      13
`define DAR_PLL_W       8
`define DAR_CLK_LO      21
`define DAR_CLK_W       4
`define DAR_SUP_LO      25
`define DAR_SUP_W       7
`define DAR_FRM_LO      32
`define DAR_FRM_W       5
`define DAR_FLT_W       37
`define DAR_LNB_BIT     5

// ----------------------------------------------------------------
// alarm byte indices and quality byte positions
// ----------------------------------------------------------------
`define DAR_AB1         0
`define DAR_AB2         1
`define DAR_AB3         2
`define DAR_AB4         3
`define DAR_ABC         4
`define DAR_AB5         5
`define DAR_QB_STATUS   8

`endif

// [inc/dar_pkg.sv]
// types shared by the alarm and status responder
package dar_pkg;
`include "dar_consts.svh"

    // ----------------------------------------------------------------
    // fill sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FILL = 2'b10
    } dar_state_e;

    // kind of response being built
    typedef enum logic [1:0] {
        KIND_LAT  = 2'h0,
        KIND_CUR  = 2'h1,
        KIND_QUAL = 2'h2
    } dar_kind_e;

    // ----------------------------------------------------------------
    // state of the fault synchroniser
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`DAR_FLT_W-1:0] s1;
        logic [`DAR_FLT_W-1:0] s2;
        logic [`DAR_FLT_W-1:0] s3;
        logic [`DAR_FLT_W-1:0] flt;
    } dar_sync_s;

    // ----------------------------------------------------------------
    // state of the responder
    // ----------------------------------------------------------------
    typedef struct packed {
        dar_state_e                        st;
        logic                              aw_got;
        logic                              w_got;
        logic [7:0]                        awaddr;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              rvalid;
        logic [31:0]                       rdata;
        logic [1:0]                        rresp;
        logic [5:0][7:0]                   lat;
        logic [`DAR_CFG_W-1:0]             cfg;
        logic [15:0]                       opcode;
        dar_kind_e                         kind;
        logic [3:0]                        ptr;
        logic [3:0]                        len;
        logic                              resp_valid;
        logic                              bad_op;
        logic [`DAR_RESP_BYTES-1:0][7:0]   resp;
    } dar_state_s;

endpackage

// [rtl/dar_sync.sv]
// three-stage synchroniser with agreement filter for the fault pins
`timescale 1ns/1ns
module dar_sync
    import dar_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // pins and filtered result
    input  wire logic [`DAR_FLT_W-1:0] pin_in,
    output logic      [`DAR_FLT_W-1:0] flt_out
);

    dar_sync_s q;   // registered state
    dar_sync_s d;   // next state

    // shift chain; a bit moves only once stages two and three agree
    always_comb begin
        d     = q;
        d.s1  = pin_in;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 | q.s3));
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flt_out = q.flt;

endmodule

// [test/dar_host.sv]
// host bus model: issues one register access at a time over the axi4-lite master side
`timescale 1ns/1ns
module dar_host (
    // clock, reset and request from the bench
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [7:0]  a,
    input  wire logic [31:0] d,
    // result of the access
    output logic             done,
    output logic [31:0]      q,
    output logic [1:0]       rsp,
    // axi4-lite master side
    output logic [7:0]       s_axi_awaddr, s_axi_araddr,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input  wire logic [31:0] s_axi_rdata
);
    // each channel holds valid and payload until its own ready edge
    always_ff @(posedge aclk) begin
        done <= 1'b0;
        if (!aresetn) begin
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        end else begin
            if (go) begin
                {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, q} <= {a, a, d, 4'hf, 32'h0};
                {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
                {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
            end
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) {s_axi_bready, done, rsp} <= {2'b01, s_axi_bresp};
            if (s_axi_rvalid && s_axi_rready) {s_axi_rready, done, rsp, q} <= {2'b01, s_axi_rresp, s_axi_rdata};
        end
    end
endmodule

// [test/tb.sv]
// self-checking bench for the alarm and status responder
`timescale 1ns/1ns
`include "dar_consts.svh"
module tb;
    logic aclk = 0, aresetn = 0, go = 0, wr = 0, done, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, ber_valid = 1, tp_ber_valid = 0;
    logic [7:0] a = 0, s_axi_awaddr, s_axi_araddr, pll_flt = 0, raw_ber_exp = 8'h05;
    logic [7:0] cor_ber_exp = 8'h07, in_level = 8'h3c, level_state = 8'hff, agc_volt = 8'h2a;
    logic [31:0] d = 0, q, s_axi_wdata, s_axi_rdata;
    logic [1:0] rsp, s_axi_bresp, s_axi_rresp, ebno_qual = 2'h3;
    logic [3:0] s_axi_wstrb, clk_flt = 0;
    logic [6:0] rx_flt = 0, sup_flt = 0;
    logic [5:0] buf_flt = 0;
    logic [4:0] frm_flt = 0;
    logic [15:0] raw_ber_man = 16'h1234, cor_ber_man = 16'h0abc, ebno_cdb = 16'h03e8;
    logic [47:0] e;
    int bad_count = 0, num_checks = 0;
    initial forever #4 aclk = ~aclk;
    dar_host u_host (.aclk, .aresetn, .go, .wr, .a, .d, .done, .q, .rsp, .s_axi_awaddr,
        .s_axi_araddr, .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bready,
        .s_axi_arvalid, .s_axi_rready, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
        .s_axi_arready, .s_axi_rvalid, .s_axi_bresp, .s_axi_rresp, .s_axi_rdata);
    dar_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_flt, .buf_flt, .pll_flt, .clk_flt, .sup_flt, .frm_flt, .raw_ber_man,
        .cor_ber_man, .raw_ber_exp, .cor_ber_exp, .ebno_cdb, .ber_valid, .tp_ber_valid,
        .ebno_qual, .in_level, .level_state, .agc_volt);
    // compare one value and count it
    task chk(string n, logic [31:0] x, logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    // one bus access, bounded wait for the answer
    task acc(logic w, logic [7:0] ad, logic [31:0] dd);
        @(posedge aclk);
        {go, wr, a, d} <= {1'b1, w, ad, dd};
        @(posedge aclk);
        go <= 1'b0;
        for (int i = 0; i < 50 && done !== 1'b1; i++) @(negedge aclk);
        if (done !== 1'b1) chk("bus answer", 1, 0);
    endtask
    // issue a query, poll until the response is ready, then compare the twelve bytes
    task qry(logic [15:0] op, logic [95:0] x);
        acc(1, `DAR_OFF_CMD, {16'h0, op});
        repeat (20) if (q[`DAR_ST_VALID] !== 1'b1) acc(0, `DAR_OFF_STAT, 0);
        chk("response ready", 32'h1, {31'h0, q[`DAR_ST_VALID]});
        for (int i = 0; i < 3; i++) begin
            acc(0, `DAR_OFF_RESP0 + 8'(4 * i), 0);
            chk("response word", x[32*i +: 32], q);
        end
    endtask
    // closing verdict
    task results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #200000;
        bad_count++;
        results;
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        acc(1, `DAR_OFF_CFG, 32'h3);
        {rx_flt, buf_flt, pll_flt, clk_flt, sup_flt, frm_flt} <= {7'h55, 6'h2a, 8'ha5, 4'h9, 7'h3c, 5'h1b};
        repeat (6) @(posedge aclk);
        e = {2'b0, frm_flt[4:2], 1'b0, frm_flt[1:0], 1'b0, sup_flt, 4'h0, clk_flt, pll_flt,
             2'b0, buf_flt, 1'b1, rx_flt};
        qry(`DAR_OP_CURRENT, {48'h0, e});
        qry(`DAR_OP_LATCHED, {48'h0, e});
        acc(1, `DAR_OFF_CFG, 32'h2);
        {rx_flt, buf_flt, pll_flt, clk_flt, sup_flt, frm_flt} <= {7'h0, 6'h20, 24'h0};
        repeat (6) @(posedge aclk);
        qry(`DAR_OP_CURRENT, 96'h80);
        qry(`DAR_OP_LATCHED, {48'h0, e});
        acc(1, `DAR_OFF_CLR, 32'h3f);
        qry(`DAR_OP_LATCHED, 96'h80);
        qry(`DAR_OP_QUALITY, {agc_volt, level_state, in_level, 4'h0, ebno_qual, tp_ber_valid,
            ber_valid, cor_ber_exp, raw_ber_exp, ebno_cdb[7:0], ebno_cdb[15:8], cor_ber_man[7:0],
            cor_ber_man[15:8], raw_ber_man[7:0], raw_ber_man[15:8]});
        acc(0, 8'h20, 0);
        chk("unmapped read", {30'h0, `DAR_AXI_DECERR}, {30'h0, rsp});
        results;
    end
endmodule
